// [sdcl_pkg.sv]
// Shared constants and types of the synthesizer divider configuration loader
package sdcl_pkg;
  // Field widths
  localparam int LOOP_W = 9;
  localparam int CODE_W = 2;
  localparam int TEST_W = 3;
  localparam int SHIFT_W = 14;
  // Field positions in the serial shift register
  localparam int SR_LOOP_LSB = 0;
  localparam int SR_CODE_LSB = 9;
  localparam int SR_TEST_LSB = 11;
  // Reference divider and synthesis accumulator
  localparam int REF_W = 4;
  localparam int ACC_W = 24;
  localparam int ACC_FRAC = 20;
  // Reset values
  localparam logic [LOOP_W-1:0] RST_LOOP_DIV = 9'h1ff;
  localparam logic [CODE_W-1:0] RST_OUT_CODE = 2'h3;
  localparam logic [TEST_W-1:0] RST_TEST_SEL = 3'h0;
  // Test select codes
  localparam logic [TEST_W-1:0] TEST_SHIFT = 3'h0;
  localparam logic [TEST_W-1:0] TEST_HIGH = 3'h1;
  localparam logic [TEST_W-1:0] TEST_REF = 3'h2;
  localparam logic [TEST_W-1:0] TEST_LOOP = 3'h3;
  localparam logic [TEST_W-1:0] TEST_SYNTH = 3'h4;
  localparam logic [TEST_W-1:0] TEST_LOW = 3'h5;
  localparam logic [TEST_W-1:0] TEST_BYPASS = 3'h6;
  localparam logic [TEST_W-1:0] TEST_SYNTH4 = 3'h7;
  localparam logic [TEST_W-1:0] TEST_FORCED = 3'h0;
  // Loop divider range that can lock
  localparam logic [LOOP_W-1:0] LOOP_MIN = 9'h0c8;
  localparam logic [LOOP_W-1:0] LOOP_MAX = 9'h190;
  // Pin timing
  localparam int CLK_NS = 25;
  localparam int PULSE_NS = 50;
  localparam int SER_CLK_MAX_MHZ = 10;
  localparam int SER_HALF_NS = 1000 / SER_CLK_MAX_MHZ / 2;
  localparam logic [3:0] CYC_PULSE = 4'((PULSE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] CYC_HALF = 4'((SER_HALF_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] SHIFT_BITS = 4'(SHIFT_W);
  // Host sequencer states
  typedef enum logic [5:0] {
    H_IDLE = 6'h01,
    H_PAR = 6'h02,
    H_SLO = 6'h04,
    H_SHI = 6'h08,
    H_LHI = 6'h10,
    H_LLO = 6'h20
  } sdcl_hstate_t;
endpackage

// [sdcl_if.sv]
// Configuration pins between the synthesizer and its controller
`timescale 1ns/10ps
interface sdcl_if;
  logic par_load;
  logic [sdcl_pkg::LOOP_W-1:0] loop_div;
  logic [sdcl_pkg::CODE_W-1:0] out_div_code;
  logic ser_clk;
  logic ser_data;
  logic ser_load;
  logic synth_out_p;
  logic synth_out_n;
  logic test_pin;
  modport dev (
    input par_load, loop_div, out_div_code, ser_clk, ser_data, ser_load,
    output synth_out_p, synth_out_n, test_pin
  );
  modport host (
    output par_load, loop_div, out_div_code, ser_clk, ser_data, ser_load,
    input synth_out_p, synth_out_n, test_pin
  );
endinterface

// [sdcl_device.sv]
// Synthesizer end: divider latches, serial loader, bypass dividers, test pin
// Function
// RULE_01: Output is reference/16 times loop over ratio
// RULE_02: Controller keeps loop divider within 200..400; host drives 511 from reset, any value with serial test code 110
// RULE_03: Code selects ratio 1, 2, 4 or 8
// RULE_04: Parallel strobe rising edge captures divider inputs
// RULE_05: Strobe low makes divider latches transparent
// RULE_06: Serial clock rise shifts data into register
// RULE_07: Serial loading works only with strobe high
// RULE_08: Stream order: test, code, then loop bits
// RULE_09: Each field is sent most significant first
// RULE_10: Serial load falling edge transfers shifted values
// RULE_11: Test select set only by serial stream
// RULE_12: Strobe low forces test select to zero
// RULE_13: Test select code drives the test multiplexer
// RULE_14: Code 110 bypasses loop using serial clock
// RULE_15: Bypass output divider divides by two minimum
// RULE_16: Bypass loop counter output is not symmetric
// RULE_17: Strobe low shows shift register top bit
// RULE_18: Controller sets parallel first, retunes serially later
`timescale 1ns/10ps
module sdcl_device (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Configuration pins
  sdcl_if.dev pins,
  // Status
  output logic [sdcl_pkg::LOOP_W-1:0] cur_loop_div,
  output logic [sdcl_pkg::CODE_W-1:0] cur_out_code,
  output logic [sdcl_pkg::TEST_W-1:0] cur_test_sel,
  output logic bypass_active,
  output logic lock_range_ok
);
  logic parallel_load_low;
  logic ser_rise;
  logic load_fall;
  logic bypass;
  logic ser_clk_q, ser_clk_d;
  logic ser_load_q, ser_load_d;
  logic [sdcl_pkg::LOOP_W-1:0] loop_q, loop_d;
  logic [sdcl_pkg::CODE_W-1:0] code_q, code_d;
  logic [sdcl_pkg::TEST_W-1:0] test_q, test_d;
  logic [sdcl_pkg::SHIFT_W-1:0] shift_q, shift_d;
  logic [sdcl_pkg::REF_W-1:0] ref_q, ref_d;
  logic [sdcl_pkg::ACC_W-1:0] phase_q, phase_d;
  logic [31:0] step;
  logic [sdcl_pkg::LOOP_W-1:0] loop_counter_out_q, loop_counter_out_d;
  logic mpulse_q, mpulse_d;
  logic [2:0] half;
  logic [2:0] ncnt_q, ncnt_d;
  logic nout_q, nout_d;
  logic synth_q, synth_d;
  logic synthn_q, synthn_d;
  logic [1:0] fdiv_q, fdiv_d;
  logic test_pin_q, test_pin_d;
  logic lock_q, lock_d;

  // Configuration latches and serial shift register
  always_comb
  begin
    parallel_load_low = !pins.par_load;
    ser_rise = pins.ser_clk && !ser_clk_q;
    load_fall = ser_load_q && !pins.ser_load;
    ser_clk_d = pins.ser_clk;
    ser_load_d = pins.ser_load;
    loop_d = loop_q;
    code_d = code_q;
    test_d = test_q;
    shift_d = shift_q;
    // Parallel path has priority; the value seen last while low is kept [RULE_04]
    if (parallel_load_low)
    begin
      loop_d = pins.loop_div; // [RULE_05]
      code_d = pins.out_div_code; // [RULE_05]
      test_d = sdcl_pkg::TEST_FORCED; // [RULE_11] [RULE_12]
    end
    else if (load_fall)
    begin
      loop_d = shift_q[sdcl_pkg::SR_LOOP_LSB +: sdcl_pkg::LOOP_W]; // [RULE_10] [RULE_08]
      code_d = shift_q[sdcl_pkg::SR_CODE_LSB +: sdcl_pkg::CODE_W]; // [RULE_10] [RULE_08]
      test_d = shift_q[sdcl_pkg::SR_TEST_LSB +: sdcl_pkg::TEST_W]; // [RULE_10] [RULE_11]
    end
    // Shifting toward the top puts the first bit sent at the top
    if (!parallel_load_low && ser_rise)
    begin
      shift_d = {shift_q[sdcl_pkg::SHIFT_W-2:0], pins.ser_data}; // [RULE_06] [RULE_07] [RULE_09]
    end
  end

  // Reference, synthesis accumulator and bypass dividers
  always_comb
  begin
    bypass = (test_q == sdcl_pkg::TEST_BYPASS);
    ref_d = ref_q + 4'h1; // [RULE_01]
    // Aliases once the output rate passes half the clock rate
    step = 32'(loop_q) << sdcl_pkg::ACC_FRAC; // [RULE_01]
    step = step >> code_q; // [RULE_03]
    phase_d = phase_q + step[sdcl_pkg::ACC_W-1:0]; // [RULE_01]
    case (code_q)
      2'h0: half = 3'h1; // [RULE_15]
      2'h1: half = 3'h1;
      2'h2: half = 3'h2;
      default: half = 3'h4;
    endcase
    loop_counter_out_d = loop_counter_out_q;
    mpulse_d = mpulse_q;
    ncnt_d = ncnt_q;
    nout_d = nout_q;
    if (!bypass)
    begin
      loop_counter_out_d = '0;
      mpulse_d = 1'b0;
      ncnt_d = 3'h0;
      nout_d = 1'b0;
    end
    else if (ser_rise)
    begin
      // One serial period high per wrap, so the duty cycle is not even
      if (({1'b0, loop_counter_out_q} + 10'h001) >= {1'b0, loop_q})
      begin
        loop_counter_out_d = '0; // [RULE_14]
        mpulse_d = 1'b1; // [RULE_16]
      end
      else
      begin
        loop_counter_out_d = loop_counter_out_q + 9'h001;
        mpulse_d = 1'b0;
      end
      if ((ncnt_q + 3'h1) >= half)
      begin
        ncnt_d = 3'h0;
        nout_d = !nout_q; // [RULE_14] [RULE_15]
      end
      else
      begin
        ncnt_d = ncnt_q + 3'h1;
      end
    end
  end

  // Output pair, test multiplexer and status
  always_comb
  begin
    synth_d = bypass ? nout_q : phase_q[sdcl_pkg::ACC_W-1]; // [RULE_14] [RULE_01]
    synthn_d = !synth_d;
    fdiv_d = fdiv_q + {1'b0, (synth_d && !synth_q)};
    lock_d = (loop_q >= sdcl_pkg::LOOP_MIN) && (loop_q <= sdcl_pkg::LOOP_MAX);
    case (test_q)
      sdcl_pkg::TEST_SHIFT: test_pin_d = shift_q[sdcl_pkg::SHIFT_W-1]; // [RULE_13] [RULE_17]
      sdcl_pkg::TEST_HIGH: test_pin_d = 1'b1; // [RULE_13]
      sdcl_pkg::TEST_REF: test_pin_d = ref_q[sdcl_pkg::REF_W-1]; // [RULE_13]
      // A locked loop counter runs at the reference rate
      sdcl_pkg::TEST_LOOP: test_pin_d = ref_q[sdcl_pkg::REF_W-1]; // [RULE_13]
      sdcl_pkg::TEST_SYNTH: test_pin_d = synth_q; // [RULE_13]
      sdcl_pkg::TEST_LOW: test_pin_d = 1'b0; // [RULE_13]
      sdcl_pkg::TEST_BYPASS: test_pin_d = mpulse_q; // [RULE_14]
      sdcl_pkg::TEST_SYNTH4: test_pin_d = fdiv_q[1]; // [RULE_13]
      default: test_pin_d = 1'b0;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ser_clk_q <= 1'b0;
      ser_load_q <= 1'b0;
      loop_q <= sdcl_pkg::RST_LOOP_DIV;
      code_q <= sdcl_pkg::RST_OUT_CODE;
      test_q <= sdcl_pkg::RST_TEST_SEL;
      shift_q <= '0;
      ref_q <= '0;
      phase_q <= '0;
      loop_counter_out_q <= '0;
      mpulse_q <= 1'b0;
      ncnt_q <= 3'h0;
      nout_q <= 1'b0;
      synth_q <= 1'b0;
      synthn_q <= 1'b1;
      fdiv_q <= 2'h0;
      test_pin_q <= 1'b0;
      lock_q <= 1'b0;
    end
    else
    begin
      ser_clk_q <= ser_clk_d;
      ser_load_q <= ser_load_d;
      loop_q <= loop_d;
      code_q <= code_d;
      test_q <= test_d;
      shift_q <= shift_d;
      ref_q <= ref_d;
      phase_q <= phase_d;
      loop_counter_out_q <= loop_counter_out_d;
      mpulse_q <= mpulse_d;
      ncnt_q <= ncnt_d;
      nout_q <= nout_d;
      synth_q <= synth_d;
      synthn_q <= synthn_d;
      fdiv_q <= fdiv_d;
      test_pin_q <= test_pin_d;
      lock_q <= lock_d;
    end
  end

  assign pins.synth_out_p = synth_q;
  assign pins.synth_out_n = synthn_q;
  assign pins.test_pin = test_pin_q;
  assign cur_loop_div = loop_q;
  assign cur_out_code = code_q;
  assign cur_test_sel = test_q;
  assign bypass_active = bypass;
  assign lock_range_ok = lock_q;
endmodule

// [sdcl_host.sv]
// Controller end: drives parallel and serial configuration of the synthesizer
`timescale 1ns/10ps
module sdcl_host (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Configuration pins
  sdcl_if.host pins,
  // Parallel command
  input wire logic par_req,
  input wire logic [sdcl_pkg::LOOP_W-1:0] par_loop_div,
  input wire logic [sdcl_pkg::CODE_W-1:0] par_code,
  // Serial command
  input wire logic ser_req,
  input wire logic [sdcl_pkg::TEST_W-1:0] ser_test,
  input wire logic [sdcl_pkg::CODE_W-1:0] ser_code,
  input wire logic [sdcl_pkg::LOOP_W-1:0] ser_loop_div,
  // Status
  output logic busy,
  output logic done,
  output logic refused,
  output logic configured
);
  sdcl_pkg::sdcl_hstate_t state_q, state_d;
  logic [3:0] cnt_q, cnt_d;
  logic [3:0] bits_q, bits_d;
  logic [sdcl_pkg::SHIFT_W-1:0] shreg_q, shreg_d;
  logic par_load_q, par_load_d;
  logic [sdcl_pkg::LOOP_W-1:0] loop_pin_q, loop_pin_d;
  logic [sdcl_pkg::CODE_W-1:0] code_pin_q, code_pin_d;
  logic ser_clk_q, ser_clk_d;
  logic ser_data_q, ser_data_d;
  logic ser_load_q, ser_load_d;
  logic done_q, done_d;
  logic refused_q, refused_d;
  logic par_ok, ser_ok, last;

  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    bits_d = bits_q;
    shreg_d = shreg_q;
    par_load_d = par_load_q;
    loop_pin_d = loop_pin_q;
    code_pin_d = code_pin_q;
    ser_clk_d = ser_clk_q;
    ser_data_d = ser_data_q;
    ser_load_d = ser_load_q;
    done_d = 1'b0;
    refused_d = 1'b0;
    last = (cnt_q <= 4'h1);
    par_ok = (par_loop_div >= sdcl_pkg::LOOP_MIN) && (par_loop_div <= sdcl_pkg::LOOP_MAX); // [RULE_02]
    ser_ok = par_load_q && ((ser_test == sdcl_pkg::TEST_BYPASS) ||
      ((ser_loop_div >= sdcl_pkg::LOOP_MIN) && (ser_loop_div <= sdcl_pkg::LOOP_MAX))); // [RULE_07] [RULE_02]
    if (!last)
    begin
      cnt_d = cnt_q - 4'h1;
    end
    case (state_q)
      sdcl_pkg::H_IDLE:
      begin
        if (par_req)
        begin
          refused_d = !par_ok;
          if (par_ok)
          begin
            loop_pin_d = par_loop_div;
            code_pin_d = par_code;
            par_load_d = 1'b0; // [RULE_18]
            cnt_d = sdcl_pkg::CYC_PULSE;
            state_d = sdcl_pkg::H_PAR;
          end
        end
        else if (ser_req)
        begin
          refused_d = !ser_ok;
          if (ser_ok)
          begin
            shreg_d = {ser_test, ser_code, ser_loop_div}; // [RULE_08]
            ser_data_d = ser_test[sdcl_pkg::TEST_W-1]; // [RULE_09]
            bits_d = sdcl_pkg::SHIFT_BITS;
            cnt_d = sdcl_pkg::CYC_HALF;
            state_d = sdcl_pkg::H_SLO;
          end
        end
      end
      sdcl_pkg::H_PAR:
      begin
        if (last)
        begin
          par_load_d = 1'b1; // [RULE_04]
          done_d = 1'b1;
          state_d = sdcl_pkg::H_IDLE;
        end
      end
      sdcl_pkg::H_SLO:
      begin
        if (last)
        begin
          ser_clk_d = 1'b1; // [RULE_06]
          cnt_d = sdcl_pkg::CYC_HALF;
          state_d = sdcl_pkg::H_SHI;
        end
      end
      sdcl_pkg::H_SHI:
      begin
        if (last)
        begin
          ser_clk_d = 1'b0;
          shreg_d = {shreg_q[sdcl_pkg::SHIFT_W-2:0], 1'b0};
          bits_d = bits_q - 4'h1;
          if (bits_q <= 4'h1)
          begin
            ser_load_d = 1'b1; // [RULE_10]
            cnt_d = sdcl_pkg::CYC_PULSE;
            state_d = sdcl_pkg::H_LHI;
          end
          else
          begin
            ser_data_d = shreg_q[sdcl_pkg::SHIFT_W-2]; // [RULE_09]
            cnt_d = sdcl_pkg::CYC_HALF;
            state_d = sdcl_pkg::H_SLO;
          end
        end
      end
      sdcl_pkg::H_LHI:
      begin
        if (last)
        begin
          ser_load_d = 1'b0; // [RULE_10]
          cnt_d = sdcl_pkg::CYC_PULSE;
          state_d = sdcl_pkg::H_LLO;
        end
      end
      sdcl_pkg::H_LLO:
      begin
        if (last)
        begin
          done_d = 1'b1;
          state_d = sdcl_pkg::H_IDLE;
        end
      end
      default:
      begin
        state_d = sdcl_pkg::H_IDLE;
      end
    endcase
  end

  // Strobe starts low at reset so the synthesizer tracks its pins
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_q <= sdcl_pkg::H_IDLE;
      cnt_q <= 4'h0;
      bits_q <= 4'h0;
      shreg_q <= '0;
      par_load_q <= 1'b0;
      loop_pin_q <= sdcl_pkg::RST_LOOP_DIV;
      code_pin_q <= sdcl_pkg::RST_OUT_CODE;
      ser_clk_q <= 1'b0;
      ser_data_q <= 1'b0;
      ser_load_q <= 1'b0;
      done_q <= 1'b0;
      refused_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      bits_q <= bits_d;
      shreg_q <= shreg_d;
      par_load_q <= par_load_d;
      loop_pin_q <= loop_pin_d;
      code_pin_q <= code_pin_d;
      ser_clk_q <= ser_clk_d;
      ser_data_q <= ser_data_d;
      ser_load_q <= ser_load_d;
      done_q <= done_d;
      refused_q <= refused_d;
    end
  end

  assign pins.par_load = par_load_q;
  assign pins.loop_div = loop_pin_q;
  assign pins.out_div_code = code_pin_q;
  assign pins.ser_clk = ser_clk_q;
  assign pins.ser_data = ser_data_q;
  assign pins.ser_load = ser_load_q;
  assign busy = (state_q != sdcl_pkg::H_IDLE);
  assign done = done_q;
  assign refused = refused_q;
  assign configured = par_load_q;
endmodule

// [sdcl_pins_sva.sv]
// Checker on the configuration pins between controller and synthesizer
`timescale 1ns/10ps
module sdcl_pins_sva (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Configuration pins
  input wire logic par_load,
  input wire logic [sdcl_pkg::LOOP_W-1:0] loop_div,
  input wire logic [sdcl_pkg::CODE_W-1:0] out_div_code,
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic ser_load,
  input wire logic synth_out_p,
  input wire logic synth_out_n,
  input wire logic test_pin
);
  logic clk_prev_q;
  logic clk_prev_d;
  logic [4:0] rises_q;
  logic [4:0] rises_d;

  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);

  // Rises are counted here, not with sampled-value functions
  always_comb
  begin
    clk_prev_d = ser_clk;
    rises_d = ser_load ? 5'h00 : rises_q + 5'(ser_clk & ~clk_prev_q);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      clk_prev_q <= 1'b0;
      rises_q <= 5'h00;
    end
    else
    begin
      clk_prev_q <= clk_prev_d;
      rises_q <= rises_d;
    end
  end

  sequence s_bit_high;
    $stable(ser_data) ##1 (ser_clk && $stable(ser_data)) ##1 !ser_clk;
  endsequence
  sequence s_load_pulse;
    ser_load ##1 ser_load ##1 !ser_load;
  endsequence
  sequence s_par_pulse;
    !par_load ##1 !par_load ##1 par_load;
  endsequence

  AST_PAIR: assert property (synth_out_p != synth_out_n)
    else $error("synth output pair not complementary");
  AST_SER_NEEDS_PAR: assert property ((ser_clk || ser_load) |-> par_load)
    else $error("serial activity with parallel strobe low");
  AST_BIT_HIGH: assert property ($rose(ser_clk) |-> s_bit_high)
    else $error("serial clock high phase or data hold wrong");
  AST_CLK_LOW: assert property ($fell(ser_clk) |-> !ser_clk ##1 !ser_clk)
    else $error("serial clock low phase too short");
  AST_LOAD_PULSE: assert property ($rose(ser_load) |-> !ser_clk throughout s_load_pulse)
    else $error("serial load pulse malformed");
  AST_LOAD_COUNT: assert property ($rose(ser_load) |-> rises_q == 5'h0e)
    else $error("serial load not after fourteen bits");
  AST_PAR_PULSE: assert property ($fell(par_load) |-> s_par_pulse)
    else $error("parallel strobe pulse malformed");
  AST_PAR_HOLD: assert property ($rose(par_load) |-> $stable(loop_div) && $stable(out_div_code))
    else $error("divider pins moved at strobe rise");
endmodule

// [synth_divider_config_loader_tb.sv]
// Self-checking bench joining controller and synthesizer ends
`timescale 1ns/10ps
module synth_divider_config_loader_tb;
  logic clk;
  logic rst;
  logic par_req;
  logic [8:0] par_loop_div;
  logic [1:0] par_code;
  logic ser_req;
  logic [2:0] ser_test;
  logic [1:0] ser_code;
  logic [8:0] ser_loop_div;
  logic busy, done, refused, configured;
  logic [8:0] cur_loop_div;
  logic [1:0] cur_out_code;
  logic [2:0] cur_test_sel;
  logic bypass_active, lock_range_ok;
  logic [13:0] wire_sr;
  logic sc_prev, sp_prev, tp_prev;
  int n_fail, n_compared, n_tog, n_rise, i, j, c0, c1;
  bit cfg;

  sdcl_if pins_if();
  sdcl_host sdcl_host_i(.clk(clk), .rst(rst), .pins(pins_if.host), .par_req(par_req),
    .par_loop_div(par_loop_div), .par_code(par_code), .ser_req(ser_req), .ser_test(ser_test),
    .ser_code(ser_code), .ser_loop_div(ser_loop_div), .busy(busy), .done(done),
    .refused(refused), .configured(configured));
  sdcl_device sdcl_device_i(.clk(clk), .rst(rst), .pins(pins_if.dev),
    .cur_loop_div(cur_loop_div), .cur_out_code(cur_out_code), .cur_test_sel(cur_test_sel),
    .bypass_active(bypass_active), .lock_range_ok(lock_range_ok));
  sdcl_pins_sva sdcl_pins_sva_i(.clk(clk), .rst(rst), .par_load(pins_if.par_load),
    .loop_div(pins_if.loop_div), .out_div_code(pins_if.out_div_code),
    .ser_clk(pins_if.ser_clk), .ser_data(pins_if.ser_data), .ser_load(pins_if.ser_load),
    .synth_out_p(pins_if.synth_out_p), .synth_out_n(pins_if.synth_out_n),
    .test_pin(pins_if.test_pin));

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Wire watcher: own copy of the shifted word, toggles and test pin rises
  always @(posedge clk)
  begin
    if (pins_if.ser_clk && !sc_prev)
      wire_sr <= {wire_sr[12:0], pins_if.ser_data};
    if (pins_if.synth_out_p !== sp_prev)
      n_tog <= n_tog + 1;
    if (pins_if.test_pin && !tp_prev)
      n_rise <= n_rise + 1;
    sc_prev <= pins_if.ser_clk;
    sp_prev <= pins_if.synth_out_p;
    tp_prev <= pins_if.test_pin;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  function automatic bit exp_refuse(input bit par, input logic [8:0] m, input logic [2:0] t);
    bit bad;
    bad = (m < sdcl_pkg::LOOP_MIN) || (m > sdcl_pkg::LOOP_MAX);
    return par ? bad : (!cfg || (bad && t != sdcl_pkg::TEST_BYPASS));
  endfunction

  // One command, then the latches and, for serial commands, the wire word are compared
  task automatic cmd(input bit par, input logic [8:0] m, input logic [1:0] n,
    input logic [2:0] t);
    bit rx;
    int k;
    rx = exp_refuse(par, m, t);
    par_req = par;
    ser_req = !par;
    par_loop_div = m;
    par_code = n;
    ser_loop_div = m;
    ser_code = n;
    ser_test = t;
    @(posedge clk);
    #1;
    par_req = 1'b0;
    ser_req = 1'b0;
    for (k = 0; k < 100 && done !== 1'b1 && refused !== 1'b1; k++)
    begin
      @(posedge clk);
      #1;
    end
    if (k == 100)
    begin
      n_fail++;
      close_out();
    end
    check(16'(refused), 16'(rx));
    check(16'(busy), 16'h0000);
    repeat (3) @(posedge clk);
    #1;
    if (!rx)
    begin
      if (par)
        cfg = 1'b1;
      check(16'(cur_loop_div), 16'(m));
      check(16'(cur_out_code), 16'(n));
      check(16'(cur_test_sel), par ? 16'h0000 : 16'(t));
      check(16'(lock_range_ok), 16'(!exp_refuse(1'b1, m, t)));
      check(16'(bypass_active), 16'(!par && t == sdcl_pkg::TEST_BYPASS));
      check(16'(configured), 16'(cfg));
      if (!par)
        check(16'(wire_sr), 16'({t, n, m}));
    end
  endtask

  initial
  begin
    rst = 1'b1;
    par_req = 1'b0;
    ser_req = 1'b0;
    par_loop_div = 9'h000;
    par_code = 2'h0;
    ser_test = 3'h0;
    ser_code = 2'h0;
    ser_loop_div = 9'h000;
    void'($urandom(69344));
    repeat (10) @(posedge clk);
    #1;
    rst = 1'b0;
    @(posedge clk);
    #1;
    check(16'(cur_loop_div), 16'h01ff);
    check(16'(cur_test_sel), 16'h0000);
    cmd(1'b0, 9'h12c, 2'h0, 3'h1);
    cmd(1'b1, 9'h0c7, 2'h0, 3'h0);
    cmd(1'b1, 9'h191, 2'h0, 3'h0);
    cmd(1'b1, 9'h0c8, 2'h0, 3'h0);
    cmd(1'b1, 9'h190, 2'h3, 3'h0);
    for (i = 0; i < 4; i++)
      cmd(1'b1, 9'(32'hc8 + $urandom % 32'hc9), 2'(i), 3'h0);
    cmd(1'b0, 9'h1c2, 2'h1, 3'h1);
    // Every test code once; bypass code leaves divide code 00 so it must act as 2
    for (i = 0; i < 8; i++)
    begin
      cmd(1'b0, 9'(32'hc8 + $urandom % 32'hc9), (i == 6) ? 2'h0 : 2'($urandom), 3'(i));
      c0 = n_rise;
      c1 = n_tog;
      repeat (160) @(posedge clk);
      #1;
      case (i)
        0: check(16'(pins_if.test_pin), 16'h0000);
        1: check(16'(pins_if.test_pin), 16'h0001);
        2, 3: check(16'(n_rise - c0), 16'h000a);
        // Edge counts at the window ends leave a small slack
        4: check(16'((2 * (n_rise - c0) - (n_tog - c1)) inside {[-3:3]}), 16'h0001);
        5: check(16'(pins_if.test_pin), 16'h0000);
        6:
        begin
          // Loop counter of 30 wraps once within the third word
          for (j = 0; j < 3; j++)
          begin
            c0 = n_tog;
            c1 = n_rise;
            cmd(1'b0, 9'h01e, 2'h1, 3'h6);
            check(16'(n_tog - c0), 16'h000e);
            check(16'(n_rise - c1), 16'((14 * (j + 1)) / 30 - (14 * j) / 30));
          end
        end
        7: check(16'((8 * (n_rise - c0) - (n_tog - c1)) inside {[-20:20]}), 16'h0001);
        default: ;
      endcase
    end
    // Last serial word had test bit 2 set; parallel low shows it on the pin
    cmd(1'b1, 9'(32'hc8 + $urandom % 32'hc9), 2'($urandom), 3'h0);
    check(16'(pins_if.test_pin), 16'h0001);
    close_out();
  end
endmodule
